//--- aps_aux_pin.sv
// auxiliary pin function block with register slave and interrupt
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module aps_aux_pin
    import aps_pkg::*;
#(
    parameter aps_option_t OPTION = disabled_option,
    parameter bit ANALOG_CONTROL = 1'b0,
    parameter int PULSE_LEN = PULSE_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic minmax_alarm,
    input wire logic counter_alarm,
    input wire logic [15:0] setpoint,
    input wire logic [15:0] measured_flow,
    input wire logic unit_passed,
    input wire logic valve_safe,
    input wire logic pin_i,
    output logic pin_o,
    output logic pin_oe,
    output logic [3:0] control_mode,
    output logic irq
);

    // ==========================================================
    // elaboration checks
    generate
        if (PULSE_LEN < 2) begin : g_bad_pulse
            $error("aps_aux_pin: PULSE_LEN must be at least 2");
        end
        if (OPTION > valve_close_input_option) begin : g_bad_option
            $error("aps_aux_pin: unknown pin option");
        end
    endgenerate

    localparam logic [3:0] DEFAULT_MODE =
        ANALOG_CONTROL ? MODE_ANALOG_SETPOINT : MODE_BUS_SETPOINT;
    localparam logic [31:0] PULSE_LOAD = 32'(PULSE_LEN - 1);

    typedef enum logic [1:0] {
        ps_idle = 2'b01,
        ps_pulse = 2'b10
    } aps_pulse_t;

    typedef struct packed {
        logic switch_on;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_mask;
        logic [1:0] pin_sync;
        logic pin_low_prev;
        aps_pulse_t pulse_state;
        logic [31:0] pulse_cnt;
        logic pin_drive;
        logic [3:0] ctrl_mode;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } aps_state_t;

    aps_state_t state_reg;
    aps_state_t state_next;
    logic wave;
    logic pin_low;
    logic [IRQ_W-1:0] events;
    logic [IRQ_W-1:0] irq_clear;

    // ==========================================================
    // decoding
    function automatic logic addr_mapped(input logic [7:0] addr);
        return addr == REG_SWITCH || addr == REG_STATUS || addr == REG_IRQ_STATUS ||
               addr == REG_IRQ_MASK || addr == REG_CONFIG;
    endfunction

    function automatic logic [31:0] read_word(input logic [7:0] addr, input aps_state_t s);
        logic [31:0] w;
        w = 32'h0000_0000;
        unique case (addr)
            REG_SWITCH: w[SWITCH_ON_BIT] = s.switch_on;
            REG_STATUS: begin
                w[STATUS_DRIVE_BIT] = s.pin_drive;
                w[STATUS_LEVEL_BIT] = s.pin_sync[1];
                w[STATUS_SAFE_BIT] = valve_safe;
                w[STATUS_MODE_LSB +: 4] = s.ctrl_mode;
            end
            REG_IRQ_STATUS: w[IRQ_W-1:0] = s.irq_status;
            REG_IRQ_MASK: w[IRQ_W-1:0] = s.irq_mask;
            REG_CONFIG: begin
                w[3:0] = OPTION;
                w[CONFIG_ANALOG_BIT] = ANALOG_CONTROL;
            end
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    // ==========================================================
    // frequency output
    aps_flow_freq #(
        .FW(FLOW_W),
        .AW(NCO_W),
        .FULL_SCALE(FLOW_FULL_SCALE),
        .STEP(NCO_STEP)
    ) u_freq (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(OPTION == flow_frequency_output_option),
        .flow(measured_flow),
        .wave(wave)
    );

    // ==========================================================
    // next state
    assign pin_low = !state_reg.pin_sync[1];

    always_comb begin
        state_next = state_reg;
        events = '0;
        irq_clear = '0;

        // pin input synchroniser
        state_next.pin_sync = {state_reg.pin_sync[0], pin_i};
        state_next.pin_low_prev = pin_low;

        // batch pulse timer
        unique case (state_reg.pulse_state)
            ps_idle: begin
                if (OPTION == batch_pulse_output_option && unit_passed) begin
                    state_next.pulse_state = ps_pulse;
                    state_next.pulse_cnt = PULSE_LOAD;
                end
            end
            ps_pulse: begin
                if (unit_passed) begin
                    state_next.pulse_cnt = PULSE_LOAD;
                end else if (state_reg.pulse_cnt == 32'h0000_0000) begin
                    state_next.pulse_state = ps_idle;
                end else begin
                    state_next.pulse_cnt = state_reg.pulse_cnt - 32'h0000_0001;
                end
            end
            default: state_next.pulse_state = ps_idle;
        endcase
        if (OPTION == batch_pulse_output_option && unit_passed) begin
            events[IRQ_BATCH] = 1'b1;
        end

        // pin drive, active low open drain
        unique case (OPTION)
            disabled_option: state_next.pin_drive = 1'b1;
            minmax_alarm_output_option: state_next.pin_drive = minmax_alarm;
            counter_alarm_output_option: state_next.pin_drive = counter_alarm;
            setpoint_shutoff_output_option: begin
                // valve safe state deliberately plays no part here
                if (ANALOG_CONTROL) begin
                    state_next.pin_drive = setpoint >= SHUTOFF_THRESHOLD;
                end else begin
                    state_next.pin_drive = setpoint != 16'h0000;
                end
            end
            remote_switch_output_option:
                state_next.pin_drive = state_reg.switch_on && !valve_safe;
            flow_frequency_output_option: state_next.pin_drive = wave;
            batch_pulse_output_option:
                state_next.pin_drive = state_reg.pulse_state == ps_pulse;
            valve_close_input_option: state_next.pin_drive = 1'b0;
            default: state_next.pin_drive = 1'b0;
        endcase

        // control mode
        if (OPTION == valve_close_input_option && pin_low) begin
            state_next.ctrl_mode = MODE_VALVE_CLOSED;
        end else begin
            state_next.ctrl_mode = DEFAULT_MODE;
        end
        if (OPTION == valve_close_input_option) begin
            events[IRQ_CLOSE_ON] = pin_low && !state_reg.pin_low_prev;
            events[IRQ_CLOSE_OFF] = !pin_low && state_reg.pin_low_prev;
        end

        // write address and data, taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            state_next.aw_got = 1'b1;
            state_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            state_next.w_got = 1'b1;
            state_next.w_data = s_axi_wdata;
            state_next.w_strb = s_axi_wstrb;
        end
        if (state_reg.aw_got && state_reg.w_got && !state_reg.bvalid) begin
            state_next.aw_got = 1'b0;
            state_next.w_got = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp = addr_mapped(state_reg.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            if (state_reg.w_strb[0]) begin
                if (state_reg.aw_addr == REG_SWITCH) begin
                    state_next.switch_on = state_reg.w_data[SWITCH_ON_BIT];
                end
                if (state_reg.aw_addr == REG_IRQ_MASK) begin
                    state_next.irq_mask = state_reg.w_data[IRQ_W-1:0];
                end
            end
        end else if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
        end

        // read, status cleared by reading it
        if (s_axi_arvalid && s_axi_arready) begin
            state_next.rvalid = 1'b1;
            state_next.rdata = read_word(s_axi_araddr, state_reg);
            state_next.rresp = addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            if (s_axi_araddr == REG_IRQ_STATUS) begin
                irq_clear = state_reg.irq_status;
            end
        end else if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
        end

        // a new event wins over a clear in the same cycle
        state_next.irq_status = (state_reg.irq_status & ~irq_clear) | events;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= '0;
            state_reg.switch_on <= SWITCH_RESET;
            state_reg.irq_mask <= IRQ_MASK_RESET;
            state_reg.pin_sync <= 2'h3;
            state_reg.pulse_state <= ps_idle;
            state_reg.ctrl_mode <= DEFAULT_MODE;
            state_reg.pin_drive <= OPTION == disabled_option;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // outputs
    assign s_axi_awready = !state_reg.aw_got && !state_reg.bvalid;
    assign s_axi_wready = !state_reg.w_got && !state_reg.bvalid;
    assign s_axi_bvalid = state_reg.bvalid;
    assign s_axi_bresp = state_reg.bresp;
    assign s_axi_arready = !state_reg.rvalid;
    assign s_axi_rvalid = state_reg.rvalid;
    assign s_axi_rdata = state_reg.rdata;
    assign s_axi_rresp = state_reg.rresp;
    assign pin_o = 1'b0;
    assign pin_oe = state_reg.pin_drive;
    assign control_mode = state_reg.ctrl_mode;
    assign irq = |(state_reg.irq_status & state_reg.irq_mask);

    // ==========================================================
    // checks
    disabled_pin_low_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (OPTION == disabled_option) |-> pin_oe && !pin_o)
        else $error("disabled pin not held low");

    minmax_follow_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (OPTION == minmax_alarm_output_option) |=> pin_oe == $past(minmax_alarm))
        else $error("pin does not follow min/max alarm");

    counter_follow_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (OPTION == counter_alarm_output_option) |=> pin_oe == $past(counter_alarm))
        else $error("pin does not follow counter alarm");

    shutoff_analog_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (OPTION == setpoint_shutoff_output_option && ANALOG_CONTROL)
        |=> pin_oe == ($past(setpoint) >= SHUTOFF_THRESHOLD))
        else $error("analog shut-off threshold wrong");

    shutoff_digital_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (OPTION == setpoint_shutoff_output_option && !ANALOG_CONTROL)
        |=> pin_oe == ($past(setpoint) != 16'h0000))
        else $error("digital shut-off threshold wrong");

    shutoff_safe_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (OPTION == setpoint_shutoff_output_option && valve_safe && setpoint >= SHUTOFF_THRESHOLD)
        |=> pin_oe)
        else $error("valve safe state changed shut-off pin");

    switch_on_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (OPTION == remote_switch_output_option && state_reg.switch_on && !valve_safe)
        |=> pin_oe)
        else $error("remote switch not driving pin");

    switch_safe_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (OPTION == remote_switch_output_option && (valve_safe || !state_reg.switch_on))
        |=> !pin_oe)
        else $error("remote switch pin not released");

    batch_pulse_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (OPTION == batch_pulse_output_option && unit_passed) |=> ##1 pin_oe[*2])
        else $error("batch pulse not started");

    close_mode_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (OPTION == valve_close_input_option && pin_low) |=> control_mode == MODE_VALVE_CLOSED)
        else $error("valve close mode not entered");

    default_mode_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (OPTION != valve_close_input_option || !pin_low) |=> control_mode == DEFAULT_MODE)
        else $error("default control mode wrong");

    irq_set_wins_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (events != '0) |=> (state_reg.irq_status & $past(events)) == $past(events))
        else $error("interrupt event lost");

    write_resp_a: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (state_reg.aw_got && state_reg.w_got && !state_reg.bvalid) |=> s_axi_bvalid)
        else $error("write response missing");

endmodule

//--- aps_pkg.sv
// constants, option codes and register map of the auxiliary pin function block
package aps_pkg;

    // ==========================================================
    // build-time pin functions
    typedef enum logic [3:0] {
        disabled_option = 4'h0,
        minmax_alarm_output_option = 4'h1,
        counter_alarm_output_option = 4'h2,
        setpoint_shutoff_output_option = 4'h3,
        remote_switch_output_option = 4'h4,
        flow_frequency_output_option = 4'h5,
        batch_pulse_output_option = 4'h6,
        valve_close_input_option = 4'h7
    } aps_option_t;

    // ==========================================================
    // control mode values
    localparam logic [3:0] MODE_BUS_SETPOINT = 4'h0;
    localparam logic [3:0] MODE_ANALOG_SETPOINT = 4'h1;
    localparam logic [3:0] MODE_VALVE_CLOSED = 4'h3;

    // ==========================================================
    // timing
    localparam int CLK_HZ = 20_000_000;
    localparam int PULSE_LEN_MS = 1000;
    localparam int PULSE_CYCLES = CLK_HZ / 1000 * PULSE_LEN_MS;
    localparam int FREQ_FULL_HZ = 10000;

    // ==========================================================
    // setpoint and flow scaling
    localparam int SETPOINT_W = 16;
    localparam int FLOW_W = 16;
    localparam logic [15:0] SETPOINT_FULL_SCALE = 16'h7D00;
    localparam logic [15:0] FLOW_FULL_SCALE = 16'h7D00;
    localparam int SHUTOFF_PERMILLE = 19;
    localparam logic [15:0] SHUTOFF_THRESHOLD =
        16'((int'(SETPOINT_FULL_SCALE) * SHUTOFF_PERMILLE + 999) / 1000);
    localparam int NCO_W = 40;
    localparam int NCO_STEP_W = 16;
    localparam longint NCO_STEP_L =
        (longint'(FREQ_FULL_HZ) << NCO_W) / (longint'(CLK_HZ) * longint'(FLOW_FULL_SCALE));
    localparam logic [15:0] NCO_STEP = 16'(NCO_STEP_L);

    // ==========================================================
    // register map
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_SWITCH = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
    localparam logic [7:0] REG_CONFIG = 8'h10;

    localparam int SWITCH_ON_BIT = 0;
    localparam int STATUS_DRIVE_BIT = 0;
    localparam int STATUS_LEVEL_BIT = 1;
    localparam int STATUS_SAFE_BIT = 2;
    localparam int STATUS_MODE_LSB = 4;
    localparam int CONFIG_ANALOG_BIT = 4;

    localparam int IRQ_W = 3;
    localparam int IRQ_BATCH = 0;
    localparam int IRQ_CLOSE_ON = 1;
    localparam int IRQ_CLOSE_OFF = 2;

    localparam logic SWITCH_RESET = 1'b0;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- aps_flow_freq.sv
// flow-proportional square wave generator
`timescale 1ns/1ps
module aps_flow_freq
    import aps_pkg::*;
#(
    parameter int FW = FLOW_W,
    parameter int AW = NCO_W,
    parameter logic [15:0] FULL_SCALE = FLOW_FULL_SCALE,
    parameter logic [15:0] STEP = NCO_STEP
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic enable,
    input wire logic [FW-1:0] flow,
    output logic wave
);

    generate
        if (FW > 16 || AW < FW + NCO_STEP_W + 1) begin : g_bad
            $error("aps_flow_freq: unsupported widths");
        end
    endgenerate

    typedef struct packed {
        logic [AW-1:0] acc;
        logic wave;
    } aps_nco_t;

    aps_nco_t state_reg;
    aps_nco_t state_next;
    logic [FW-1:0] flow_clamped;

    always_comb begin
        state_next = state_reg;
        // negative flow reads as zero, excess as full scale
        if (flow[FW-1]) begin
            flow_clamped = '0;
        end else if (flow > FW'(FULL_SCALE)) begin
            flow_clamped = FW'(FULL_SCALE);
        end else begin
            flow_clamped = flow;
        end
        if (enable) begin
            state_next.acc = state_reg.acc + AW'(flow_clamped * STEP);
        end else begin
            state_next.acc = '0;
        end
        state_next.wave = state_next.acc[AW-1];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign wave = state_reg.wave;

endmodule

//--- aps_ext_load.sv
// external load on the auxiliary pin: pull-up plus an optional switch to ground
`timescale 1ns/1ps
module aps_ext_load
    import aps_pkg::*;
(
    input wire logic pin_o,
    input wire logic pin_oe,
    input wire logic hold_low,
    output logic level
);
    // ==========================================================
    // wired line: device driver or external switch pulls low, else pull-up
    assign level = ((pin_oe && !pin_o) || hold_low) ? 1'b0 : 1'b1;
endmodule

//--- tb.sv
// self-checking testbench of the auxiliary pin function block
`timescale 1ns/1ps
module tb
    import aps_pkg::*;
;
    // ==========================================================
    // one instance per build option, two for the setpoint shut-off option (bus and analog setpoint)
    localparam int N = 9;
    localparam aps_option_t OPT [N] = '{disabled_option, minmax_alarm_output_option,
        counter_alarm_output_option, setpoint_shutoff_output_option,
        setpoint_shutoff_output_option, remote_switch_output_option,
        flow_frequency_output_option, batch_pulse_output_option, valve_close_input_option};
    localparam bit ANA [N] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    localparam logic [15:0] SP [4] = '{16'h0000, 16'h0001, 16'h025F, 16'h0260};
    localparam logic [15:0] FL [3] = '{16'h0000, 16'h3E80, 16'h7D00};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic [N-1:0] awv = '0, wv = '0, arv = '0, brd = '0, rrd = '0, hold = '0;
    wire logic [N-1:0] awr, wrd, arr, bv, rv, po, oe, irq, lvl;
    wire logic [1:0] bresp [N];
    wire logic [1:0] rresp [N];
    wire logic [31:0] rdata [N];
    wire logic [3:0] mode [N];
    logic minmax = 1'b0, cnt_alarm = 1'b0, unit = 1'b0, safe = 1'b0;
    logic [15:0] setpoint = 16'h0000, flow = 16'h0000;
    int miscompares = 0, compares = 0;

    always #25 aclk = ~aclk;

    for (genvar i = 0; i < N; i++) begin : g
        aps_aux_pin #(.OPTION(OPT[i]), .ANALOG_CONTROL(ANA[i]), .PULSE_LEN(8)) DUT (
            .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
            .s_axi_awvalid(awv[i]), .s_axi_awready(awr[i]), .s_axi_wdata(wdata),
            .s_axi_wstrb(wstrb), .s_axi_wvalid(wv[i]), .s_axi_wready(wrd[i]),
            .s_axi_bresp(bresp[i]), .s_axi_bvalid(bv[i]), .s_axi_bready(brd[i]),
            .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arv[i]),
            .s_axi_arready(arr[i]), .s_axi_rdata(rdata[i]), .s_axi_rresp(rresp[i]),
            .s_axi_rvalid(rv[i]), .s_axi_rready(rrd[i]), .minmax_alarm(minmax),
            .counter_alarm(cnt_alarm), .setpoint(setpoint), .measured_flow(flow),
            .unit_passed(unit), .valve_safe(safe), .pin_i(lvl[i]), .pin_o(po[i]),
            .pin_oe(oe[i]), .control_mode(mode[i]), .irq(irq[i]));
        aps_ext_load ld (.pin_o(po[i]), .pin_oe(oe[i]), .hold_low(hold[i]), .level(lvl[i]));
    end

    // ==========================================================
    // checking and bus tasks
    task automatic end_of_test();
        if (miscompares == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(logic [31:0] got, logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: word %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chkb(logic got, logic exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: bit %b, expected %b", $time, got, exp);
        end
    endtask

    task automatic cyc(int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask

    task automatic wr(int k, logic [7:0] a, logic [31:0] d, logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awv[k] <= 1'b1;
        wv[k] <= 1'b1;
        brd[k] <= 1'b1;
        do begin
            @(posedge aclk);
            if (awr[k] === 1'b1) awv[k] <= 1'b0;
            if (wrd[k] === 1'b1) wv[k] <= 1'b0;
        end while (bv[k] !== 1'b1);
        chkb(awr[k], 1'b0);
        chk(32'(bresp[k]), 32'(er));
        brd[k] <= 1'b0;
    endtask

    task automatic rd(int k, logic [7:0] a, logic [31:0] ed, logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arv[k] <= 1'b1;
        rrd[k] <= 1'b1;
        do begin
            @(posedge aclk);
            if (arr[k] === 1'b1) arv[k] <= 1'b0;
        end while (rv[k] !== 1'b1);
        chkb(arr[k], 1'b0);
        chk(rdata[k], ed);
        chk(32'(rresp[k]), 32'(er));
        rrd[k] <= 1'b0;
    endtask

    // ==========================================================
    // test sequence
    initial begin
        int c;
        logic p;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        cyc(1);
        for (int k = 0; k < N; k++) begin
            chkb(oe[k], k == 0);
            chk(32'(mode[k]), (k == 4 || k == 8) ? 32'h1 : 32'h0);
            rd(k, REG_CONFIG, (32'(ANA[k]) << 4) | 32'(OPT[k]), RESP_OKAY);
            wr(k, REG_CONFIG, 32'h0, RESP_OKAY);
            rd(k, REG_CONFIG, (32'(ANA[k]) << 4) | 32'(OPT[k]), RESP_OKAY);
        end
        @(posedge aclk);
        minmax <= 1'b1;
        cyc(2);
        chkb(oe[1], 1'b1);
        chkb(po[1], 1'b0);
        chkb(oe[2], 1'b0);
        @(posedge aclk);
        minmax <= 1'b0;
        cnt_alarm <= 1'b1;
        cyc(2);
        chkb(oe[1], 1'b0);
        chkb(oe[2], 1'b1);
        @(posedge aclk);
        cnt_alarm <= 1'b0;
        cyc(2);
        chkb(oe[2], 1'b0);
        // setpoint steps with the safe state toggling underneath
        for (int j = 0; j < 4; j++) begin
            @(posedge aclk);
            setpoint <= SP[j];
            safe <= j[0];
            cyc(2);
            chkb(oe[3], j > 0);
            chkb(oe[4], j == 3);
        end
        wr(5, REG_SWITCH, 32'h1, RESP_OKAY);
        cyc(2);
        chkb(oe[5], 1'b0);
        rd(5, REG_SWITCH, 32'h1, RESP_OKAY);
        @(posedge aclk);
        safe <= 1'b0;
        cyc(2);
        chkb(oe[5], 1'b1);
        wr(5, REG_SWITCH, 32'h0, RESP_OKAY);
        cyc(2);
        chkb(oe[5], 1'b0);
        // a write without its low byte lane leaves the switch alone
        @(posedge aclk);
        wstrb <= 4'hE;
        wr(5, REG_SWITCH, 32'h1, RESP_OKAY);
        rd(5, REG_SWITCH, 32'h0, RESP_OKAY);
        wstrb <= 4'hF;
        wr(5, 8'h20, 32'h1, RESP_SLVERR);
        rd(5, 8'h20, 32'h0, RESP_SLVERR);
        // batch pulse with the interrupt masked, then unmasked and cleared
        @(posedge aclk);
        unit <= 1'b1;
        @(posedge aclk);
        unit <= 1'b0;
        c = 0;
        repeat (30) begin
            cyc(1);
            if (oe[7] === 1'b1) c++;
        end
        chk(32'(c), 32'h8);
        chkb(irq[7], 1'b0);
        wr(7, REG_IRQ_MASK, 32'h1, RESP_OKAY);
        cyc(2);
        chkb(irq[7], 1'b1);
        rd(7, REG_IRQ_STATUS, 32'h1, RESP_OKAY);
        cyc(2);
        chkb(irq[7], 1'b0);
        rd(7, REG_IRQ_STATUS, 32'h0, RESP_OKAY);
        @(posedge aclk);
        hold[8] <= 1'b1;
        cyc(5);
        chk(32'(mode[8]), 32'h3);
        rd(8, REG_STATUS, 32'(MODE_VALVE_CLOSED) << STATUS_MODE_LSB, RESP_OKAY);
        @(posedge aclk);
        hold[8] <= 1'b0;
        cyc(5);
        chk(32'(mode[8]), 32'h1);
        rd(8, REG_STATUS, (32'(MODE_ANALOG_SETPOINT) << STATUS_MODE_LSB) |
            (32'h1 << STATUS_LEVEL_BIT), RESP_OKAY);
        rd(8, REG_IRQ_STATUS, 32'h6, RESP_OKAY);
        chkb(irq[8], 1'b0);
        // rising edges in 1 ms: 0, 5 and 10 at 0, 50 and 100 percent flow
        for (int j = 0; j < 3; j++) begin
            @(posedge aclk);
            flow <= FL[j];
            cyc(100);
            c = 0;
            p = oe[6];
            repeat (20000) begin
                cyc(1);
                if (oe[6] === 1'b1 && p === 1'b0) c++;
                p = oe[6];
            end
            chkb(c >= 5 * j - 1 && c <= 5 * j + 1, 1'b1);
        end
        chkb(oe[0], 1'b1);
        end_of_test();
    end

    // ==========================================================
    // watchdog: the sequence needs about 3.0 ms
    initial begin
        #(4_000_000);
        miscompares++;
        end_of_test();
    end
endmodule
